// File: hdl/bit_stack.sv
/*
  One-bit LIFO built from flip-flops, used for the result stack and for
  the reserved block results of the executor.
  Assumes push and pop are never raised together and that rst_n is a
  reset already synchronised to clk.
*/
`timescale 1ns/10ps

module bit_stack #(
  parameter int DEPTH = 8,
  parameter int LW    = 4
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          push,
  input  wire logic          pop,
  input  wire logic          push_bit,
  output logic               top_bit,
  output logic [LW-1:0]      level,
  output logic               overflow,
  output logic               underflow
);

  localparam logic [LW-1:0] FULL  = LW'(DEPTH);
  localparam logic [LW-1:0] EMPTY = '0;

  logic [DEPTH-1:0] store;
  logic [DEPTH-1:0] next_store;
  logic [LW-1:0]    next_level;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  // Entry 0 is the top. A push on a full stack drops the oldest entry,
  // so the newest results stay reachable; the caller sees the overflow.
  always_comb begin
    next_store = store;
    next_level = level;
    overflow   = push && (level == FULL);
    underflow  = pop && (level == EMPTY);
    top_bit    = (level != EMPTY) && store[0];
    if (push) begin
      next_store = {store[DEPTH-2:0], push_bit};
      if (level != FULL) begin
        next_level = level + LW'(1);
      end
    end else if (pop) begin
      next_store = {1'b0, store[DEPTH-1:1]};
      if (level != EMPTY) begin
        next_level = level - LW'(1);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      store <= '0;
      level <= '0;
    end else begin
      store <= next_store;
      level <= next_level;
    end
  end

endmodule : bit_stack

// File: hdl/ladder_bit_logic_executor.sv
/*
  Bit-serial boolean executor for the built-in ladder-logic function:
  contacts, block joins, result stack, negation, coil drive, latch, clear.
  Assumes one instruction per cycle from a program sequencer on clk, input
  points on asynchronous pins, timer and counter contacts from logic on clk.
*/
// Functional notes
// - Load saves accumulator, then loads contact status.
// - Series contact ANDs status into accumulator.
// - Parallel open contact ORs status into accumulator.
// - Parallel closed contact ORs inverted status in.
// - Block series join ANDs reserved result in.
// - Block parallel join ORs reserved result in.
// - Push copies accumulator, stack pointer plus one.
// - Peek loads top entry, pointer unchanged.
// - Pop loads top entry, pointer minus one.
// - Negate complements accumulator for later instructions.
// - Coil drive writes accumulator to Y or M.
// - Coil state follows result; contacts follow coil.
// - Latch with true result sets point on; it stays on.
// - Latched point clears by clear instruction with true result or by coil drive with false result.
`timescale 1ns/10ps

module ladder_bit_logic_executor (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         instr_valid,
  input  wire logic [3:0]   instr_opcode,
  input  wire logic [2:0]   instr_class,
  input  wire logic [7:0]   instr_index,
  input  wire logic         fault_clear,
  input  wire logic [15:0]  input_pins,
  input  wire logic [15:0]  timer_contact,
  input  wire logic [7:0]   counter_contact,
  output logic              acc,
  output logic [15:0]       coil_y,
  output logic [159:0]      relay_m,
  output logic              instr_done,
  output logic              operand_fault,
  output logic              stack_error,
  output logic [3:0]        result_level,
  output logic [3:0]        block_level
);

  // ----------------------------------------------------------------------
  // Operand checks
  // ----------------------------------------------------------------------
  // Legality lives in functions because both the contact read and the
  // fault flag decode the same class and index fields.
  function automatic logic contact_ok(input logic [2:0] cls, input logic [7:0] idx);
    case (cls)
      ladder_pkg::CLASS_INPUT:   contact_ok = idx < ladder_pkg::INPUT_LIMIT;
      ladder_pkg::CLASS_OUTPUT:  contact_ok = idx < ladder_pkg::OUTPUT_LIMIT;
      ladder_pkg::CLASS_RELAY:   contact_ok = idx < ladder_pkg::RELAY_LIMIT;
      ladder_pkg::CLASS_TIMER:   contact_ok = idx < ladder_pkg::TIMER_LIMIT;
      ladder_pkg::CLASS_COUNTER: contact_ok = idx < ladder_pkg::COUNTER_LIMIT;
      default:                   contact_ok = 1'b0;
    endcase
  endfunction : contact_ok

  function automatic logic coil_ok(input logic [2:0] cls, input logic [7:0] idx);
    case (cls)
      ladder_pkg::CLASS_OUTPUT: coil_ok = idx < ladder_pkg::OUTPUT_LIMIT;
      ladder_pkg::CLASS_RELAY:  coil_ok = idx < ladder_pkg::RELAY_LIMIT;
      default:                  coil_ok = 1'b0;
    endcase
  endfunction : coil_ok

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  // The reset asserts at once but releases on the second edge, so no flop
  // leaves reset with the release inside its setup window.
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ----------------------------------------------------------------------
  // Input point synchroniser
  // ----------------------------------------------------------------------
  // A bit changes only when the second and third stages agree, which also
  // rejects a one-cycle glitch; the cost is three to four cycles of delay.
  logic [15:0] in_s1;
  logic [15:0] in_s2;
  logic [15:0] in_s3;
  logic [15:0] in_stable;
  logic [15:0] next_in_stable;

  always_comb begin
    next_in_stable = (in_s2 & in_s3) | (in_stable & (in_s2 ^ in_s3));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_s1     <= '0;
      in_s2     <= '0;
      in_s3     <= '0;
      in_stable <= '0;
    end else begin
      in_s1     <= input_pins;
      in_s2     <= in_s1;
      in_s3     <= in_s2;
      in_stable <= next_in_stable;
    end
  end

  // ----------------------------------------------------------------------
  // Stacks
  // ----------------------------------------------------------------------
  logic res_push;
  logic res_pop;
  logic res_top;
  logic res_over;
  logic res_under;
  logic blk_push;
  logic blk_pop;
  logic blk_top;

  bit_stack #(
    .DEPTH (ladder_pkg::RESULT_DEPTH),
    .LW    (ladder_pkg::LEVEL_WIDTH)
  ) u_result_stack (
    .clk       (clk),
    .rst_n     (rst_n),
    .push      (res_push),
    .pop       (res_pop),
    .push_bit  (acc),
    .top_bit   (res_top),
    .level     (result_level),
    .overflow  (res_over),
    .underflow (res_under)
  );

  // Every legal load reserves the previous result here; a rung start that is
  // never joined simply ages out of the bottom, so overflow is not an error.
  bit_stack #(
    .DEPTH (ladder_pkg::BLOCK_DEPTH),
    .LW    (ladder_pkg::LEVEL_WIDTH)
  ) u_block_stack (
    .clk       (clk),
    .rst_n     (rst_n),
    .push      (blk_push),
    .pop       (blk_pop),
    .push_bit  (acc),
    .top_bit   (blk_top),
    .level     (block_level),
    .overflow  (),
    .underflow ()
  );

  // ----------------------------------------------------------------------
  // Execute
  // ----------------------------------------------------------------------
  ladder_pkg::opcode_type op;
  logic           contact;
  logic           legal;
  logic           wr_en;
  logic           wr_bit;
  logic           next_acc;
  logic [15:0]    next_coil_y;
  logic [159:0]   next_relay_m;
  logic           next_done;
  logic           next_operand_fault;
  logic           next_stack_error;

  always_comb begin
    op = ladder_pkg::opcode_type'(instr_opcode);
    contact = 1'b0;
    if (contact_ok(instr_class, instr_index)) begin
      case (instr_class)
        ladder_pkg::CLASS_INPUT:  contact = in_stable[instr_index[3:0]];
        ladder_pkg::CLASS_OUTPUT: contact = coil_y[instr_index[3:0]];
        ladder_pkg::CLASS_RELAY:  contact = relay_m[instr_index];
        ladder_pkg::CLASS_TIMER:  contact = timer_contact[instr_index[3:0]];
        default:                  contact = counter_contact[instr_index[2:0]];
      endcase
    end
    next_acc     = acc;
    next_coil_y  = coil_y;
    next_relay_m = relay_m;
    res_push     = 1'b0;
    res_pop      = 1'b0;
    blk_push     = 1'b0;
    blk_pop      = 1'b0;
    wr_en        = 1'b0;
    wr_bit       = 1'b0;
    legal        = 1'b1;
    next_done    = instr_valid;
    if (instr_valid) begin
      case (op)
        ladder_pkg::op_load_a_contact: begin
          legal    = contact_ok(instr_class, instr_index);
          blk_push = legal;
          next_acc = legal ? contact : acc;
        end
        ladder_pkg::op_load_b_contact: begin
          legal    = contact_ok(instr_class, instr_index);
          blk_push = legal;
          next_acc = legal ? !contact : acc;
        end
        ladder_pkg::op_series_a_contact: begin
          legal    = contact_ok(instr_class, instr_index);
          next_acc = legal ? (acc & contact) : acc;
        end
        ladder_pkg::op_series_b_contact: begin
          legal    = contact_ok(instr_class, instr_index);
          next_acc = legal ? (acc & !contact) : acc;
        end
        ladder_pkg::op_parallel_a_contact: begin
          legal    = contact_ok(instr_class, instr_index);
          next_acc = legal ? (acc | contact) : acc;
        end
        ladder_pkg::op_parallel_b_contact: begin
          legal    = contact_ok(instr_class, instr_index);
          next_acc = legal ? (acc | !contact) : acc;
        end
        ladder_pkg::op_block_series_join: begin
          blk_pop  = 1'b1;
          next_acc = acc & blk_top;
        end
        ladder_pkg::op_block_parallel_join: begin
          blk_pop  = 1'b1;
          next_acc = acc | blk_top;
        end
        ladder_pkg::op_push_result: begin
          res_push = 1'b1;
        end
        ladder_pkg::op_peek_result: begin
          next_acc = res_top;
        end
        ladder_pkg::op_pop_result: begin
          res_pop  = 1'b1;
          next_acc = res_top;
        end
        ladder_pkg::op_negate_result: begin
          next_acc = !acc;
        end
        ladder_pkg::op_drive_coil: begin
          legal  = coil_ok(instr_class, instr_index);
          wr_en  = legal;
          wr_bit = acc;
        end
        ladder_pkg::op_latch_point: begin
          legal  = coil_ok(instr_class, instr_index);
          wr_en  = legal && acc;
          wr_bit = 1'b1;
        end
        ladder_pkg::op_clear_point: begin
          legal  = coil_ok(instr_class, instr_index);
          wr_en  = legal && acc;
          wr_bit = 1'b0;
        end
        default: begin
          legal = 1'b1;
        end
      endcase
    end
    // A point holds its value between writes, so a latched point stays on
    // until a clear with a true result or a coil drive with a false result addresses it.
    if (wr_en) begin
      if (instr_class == ladder_pkg::CLASS_OUTPUT) begin
        next_coil_y[instr_index[3:0]] = wr_bit;
      end else begin
        next_relay_m[instr_index] = wr_bit;
      end
    end
    // Sticky flags: a new event in the clearing cycle wins over the clear.
    next_operand_fault = (operand_fault && !fault_clear) || !legal;
    next_stack_error   = (stack_error && !fault_clear) || res_over || res_under;
  end

  // Every point and flag leaves from a flop, so logic that reads coil_y or
  // relay_m never sees the decode settle within a cycle.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc           <= ladder_pkg::ACC_RESET;
      coil_y        <= {ladder_pkg::OUTPUT_POINTS{ladder_pkg::POINT_RESET}};
      relay_m       <= {ladder_pkg::RELAY_POINTS{ladder_pkg::POINT_RESET}};
      instr_done    <= ladder_pkg::FLAG_RESET;
      operand_fault <= ladder_pkg::FLAG_RESET;
      stack_error   <= ladder_pkg::FLAG_RESET;
    end else begin
      acc           <= next_acc;
      coil_y        <= next_coil_y;
      relay_m       <= next_relay_m;
      instr_done    <= next_done;
      operand_fault <= next_operand_fault;
      stack_error   <= next_stack_error;
    end
  end

endmodule : ladder_bit_logic_executor

// File: hdl/ladder_pkg.sv
/*
  Shared constants for the ladder bit-logic executor: opcodes, operand
  classes, point counts, stack depths and reset values.
  Assumes nothing of its surroundings; it holds definitions only.
*/
package ladder_pkg;

  // ----------------------------------------------------------------------
  // Instruction opcodes
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    op_nop                 = 4'h0,
    op_load_a_contact      = 4'h1,
    op_load_b_contact      = 4'h2,
    op_series_a_contact    = 4'h3,
    op_series_b_contact    = 4'h4,
    op_parallel_a_contact  = 4'h5,
    op_parallel_b_contact  = 4'h6,
    op_block_series_join   = 4'h7,
    op_block_parallel_join = 4'h8,
    op_push_result         = 4'h9,
    op_peek_result         = 4'ha,
    op_pop_result          = 4'hb,
    op_negate_result       = 4'hc,
    op_drive_coil          = 4'hd,
    op_latch_point         = 4'he,
    op_clear_point         = 4'hf
  } opcode_type;

  // ----------------------------------------------------------------------
  // Operand classes and point counts
  // ----------------------------------------------------------------------
  localparam logic [2:0] CLASS_INPUT   = 3'h0;
  localparam logic [2:0] CLASS_OUTPUT  = 3'h1;
  localparam logic [2:0] CLASS_RELAY   = 3'h2;
  localparam logic [2:0] CLASS_TIMER   = 3'h3;
  localparam logic [2:0] CLASS_COUNTER = 3'h4;
  localparam logic [2:0] CLASS_DATA    = 3'h5;

  localparam int INPUT_POINTS   = 16;
  localparam int OUTPUT_POINTS  = 16;
  localparam int RELAY_POINTS   = 160;
  localparam int TIMER_POINTS   = 16;
  localparam int COUNTER_POINTS = 8;

  localparam logic [7:0] INPUT_LIMIT   = 8'h10;
  localparam logic [7:0] OUTPUT_LIMIT  = 8'h10;
  localparam logic [7:0] RELAY_LIMIT   = 8'ha0;
  localparam logic [7:0] TIMER_LIMIT   = 8'h10;
  localparam logic [7:0] COUNTER_LIMIT = 8'h08;

  // ----------------------------------------------------------------------
  // Stacks and reset values
  // ----------------------------------------------------------------------
  localparam int RESULT_DEPTH = 8;
  localparam int BLOCK_DEPTH  = 8;
  localparam int LEVEL_WIDTH  = 4;

  localparam logic ACC_RESET  = 1'b0;
  localparam logic FLAG_RESET = 1'b0;
  localparam logic POINT_RESET = 1'b0;

endpackage : ladder_pkg

// File: tb/ladder_checker.sv
/*
  Port-level assertions for the ladder bit-logic executor.
  Assumes it is bound to the executor top; one clock, reset low.
*/
`timescale 1ns/10ps

module ladder_checker (
  input wire logic         clk,
  input wire logic         rstn,
  input wire logic         instr_valid,
  input wire logic [3:0]   instr_opcode,
  input wire logic [2:0]   instr_class,
  input wire logic [7:0]   instr_index,
  input wire logic         fault_clear,
  input wire logic [15:0]  timer_contact,
  input wire logic         acc,
  input wire logic [15:0]  coil_y,
  input wire logic         instr_done,
  input wire logic         operand_fault,
  input wire logic         stack_error,
  input wire logic [3:0]   result_level
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  logic is_t;
  logic is_op;
  // Timer contacts are used directly, so they make a clean reference.
  assign is_t = instr_valid && instr_class == ladder_pkg::CLASS_TIMER && instr_index[7:4] == 4'h0;
  assign is_op = instr_valid && instr_opcode inside {4'hd, 4'he, 4'hf};

  property p_done;
    instr_valid |=> instr_done;
  endproperty
  a_done: assert property (p_done)
    else $error("no done after instruction");
  property p_load;
    is_t && instr_opcode == 4'h1 |=> acc == $past(timer_contact[instr_index[3:0]]);
  endproperty
  a_load: assert property (p_load)
    else $error("load result wrong");
  property p_ser;
    is_t && instr_opcode == 4'h3 |=> acc == ($past(acc) & $past(timer_contact[instr_index[3:0]]));
  endproperty
  a_ser: assert property (p_ser)
    else $error("series result wrong");
  property p_par_a;
    is_t && instr_opcode == 4'h5 |=> acc == ($past(acc) | $past(timer_contact[instr_index[3:0]]));
  endproperty
  a_par_a: assert property (p_par_a)
    else $error("open parallel result wrong");
  property p_par_b;
    is_t && instr_opcode == 4'h6 |=> acc == ($past(acc) | !$past(timer_contact[instr_index[3:0]]));
  endproperty
  a_par_b: assert property (p_par_b)
    else $error("closed parallel result wrong");
  property p_data;
    instr_valid && instr_opcode inside {4'h5, 4'h6} && instr_class == ladder_pkg::CLASS_DATA
      |=> operand_fault && acc == $past(acc);
  endproperty
  a_data: assert property (p_data)
    else $error("data operand not refused");
  property p_push;
    instr_valid && instr_opcode == 4'h9 && result_level < 4'h8
      |=> result_level == $past(result_level) + 4'h1;
  endproperty
  a_push: assert property (p_push)
    else $error("push level wrong");
  property p_peek;
    instr_valid && instr_opcode == 4'ha |=> $stable(result_level);
  endproperty
  a_peek: assert property (p_peek)
    else $error("peek moved level");
  property p_pop;
    instr_valid && instr_opcode == 4'hb && result_level != 4'h0
      |=> result_level == $past(result_level) - 4'h1;
  endproperty
  a_pop: assert property (p_pop)
    else $error("pop level wrong");
  property p_neg;
    instr_valid && instr_opcode == 4'hc |=> acc != $past(acc);
  endproperty
  a_neg: assert property (p_neg)
    else $error("negate failed");
  property p_coil;
    instr_valid && instr_opcode == 4'hd && instr_class == ladder_pkg::CLASS_OUTPUT
      && instr_index[7:4] == 4'h0 |=> coil_y[$past(instr_index[3:0])] == $past(acc);
  endproperty
  a_coil: assert property (p_coil)
    else $error("coil not written");
  property p_hold;
    !is_op |=> $stable(coil_y);
  endproperty
  a_hold: assert property (p_hold)
    else $error("output point changed");
  property p_err;
    stack_error && !fault_clear |=> stack_error;
  endproperty
  a_err: assert property (p_err)
    else $error("stack error not sticky");
endmodule : ladder_checker

bind ladder_bit_logic_executor ladder_checker u_chk (
  .clk(clk), .rstn(rstn), .instr_valid(instr_valid), .instr_opcode(instr_opcode),
  .instr_class(instr_class), .instr_index(instr_index), .fault_clear(fault_clear),
  .timer_contact(timer_contact), .acc(acc), .coil_y(coil_y), .instr_done(instr_done),
  .operand_fault(operand_fault), .stack_error(stack_error), .result_level(result_level)
);

// File: tb/ladder_points_model.sv
/*
  Far-side device points: input pins, timer and counter contacts.
  Assumes static patterns; counter contacts mirror inverted timers.
*/
`timescale 1ns/10ps

module ladder_points_model #(
  parameter logic [15:0] X_PAT = 16'h0f0f,
  parameter logic [15:0] T_PAT = 16'ha5c3
) (
  output logic [15:0] input_pins,
  output logic [15:0] timer_contact,
  output logic [7:0]  counter_contact
);
  assign input_pins = X_PAT;
  assign timer_contact = T_PAT;
  assign counter_contact = ~T_PAT[7:0];
endmodule : ladder_points_model

// File: tb/tb.sv
/*
  Self-checking bench for the ladder executor: a program table, then
  refusals, stack limits and a mid-run reset.
  Assumes the points model supplies timers a5c3, counters 3c, pins 0f0f.
*/
`timescale 1ns/10ps

module tb;
  typedef struct {
    logic [3:0]  op;
    logic [2:0]  c;
    logic [7:0]  i;
    logic        a;
    logic [3:0]  l;
    logic [15:0] y;
    logic [1:0]  m;
  } row_type;

  logic         clk = 1'b0;
  logic         rstn = 1'b0;
  logic         instr_valid = 1'b0;
  logic [3:0]   instr_opcode = 4'h0;
  logic [2:0]   instr_class = 3'h0;
  logic [7:0]   instr_index = 8'h00;
  logic         fault_clear = 1'b0;
  logic [15:0]  input_pins;
  logic [15:0]  timer_contact;
  logic [7:0]   counter_contact;
  logic         acc;
  logic [15:0]  coil_y;
  logic [159:0] relay_m;
  logic         instr_done;
  logic         operand_fault;
  logic         stack_error;
  logic [3:0]   result_level;
  logic [3:0]   block_level;
  int           n_errors = 0;
  int           samples_checked = 0;
  row_type      rows [28] = '{
    '{4'h1, 3'h3, 8'h00, 1'b1, 4'h0, 16'h0000, 2'b00},
    '{4'h3, 3'h3, 8'h02, 1'b0, 4'h0, 16'h0000, 2'b00},
    '{4'h5, 3'h3, 8'h02, 1'b0, 4'h0, 16'h0000, 2'b00},
    '{4'h5, 3'h3, 8'h06, 1'b1, 4'h0, 16'h0000, 2'b00},
    '{4'hc, 3'h0, 8'h00, 1'b0, 4'h0, 16'h0000, 2'b00},
    '{4'h6, 3'h3, 8'h03, 1'b1, 4'h0, 16'h0000, 2'b00},
    '{4'hc, 3'h0, 8'h00, 1'b0, 4'h0, 16'h0000, 2'b00},
    '{4'h6, 3'h3, 8'h00, 1'b0, 4'h0, 16'h0000, 2'b00},
    '{4'h5, 3'h5, 8'h00, 1'b0, 4'h0, 16'h0000, 2'b00},
    '{4'h1, 3'h0, 8'h00, 1'b1, 4'h0, 16'h0000, 2'b00},
    '{4'h8, 3'h0, 8'h00, 1'b1, 4'h0, 16'h0000, 2'b00},
    '{4'h9, 3'h0, 8'h00, 1'b1, 4'h1, 16'h0000, 2'b00},
    '{4'hc, 3'h0, 8'h00, 1'b0, 4'h1, 16'h0000, 2'b00},
    '{4'h2, 3'h4, 8'h00, 1'b1, 4'h1, 16'h0000, 2'b00},
    '{4'h7, 3'h0, 8'h00, 1'b0, 4'h1, 16'h0000, 2'b00},
    '{4'ha, 3'h0, 8'h00, 1'b1, 4'h1, 16'h0000, 2'b00},
    '{4'hd, 3'h1, 8'h03, 1'b1, 4'h1, 16'h0008, 2'b00},
    '{4'hd, 3'h2, 8'h9f, 1'b1, 4'h1, 16'h0008, 2'b10},
    '{4'h4, 3'h1, 8'h03, 1'b0, 4'h1, 16'h0008, 2'b10},
    '{4'h5, 3'h1, 8'h03, 1'b1, 4'h1, 16'h0008, 2'b10},
    '{4'hc, 3'h0, 8'h00, 1'b0, 4'h1, 16'h0008, 2'b10},
    '{4'hb, 3'h0, 8'h00, 1'b1, 4'h0, 16'h0008, 2'b10},
    '{4'he, 3'h2, 8'h05, 1'b1, 4'h0, 16'h0008, 2'b11},
    '{4'hc, 3'h0, 8'h00, 1'b0, 4'h0, 16'h0008, 2'b11},
    '{4'he, 3'h2, 8'h05, 1'b0, 4'h0, 16'h0008, 2'b11},
    '{4'hf, 3'h2, 8'h05, 1'b0, 4'h0, 16'h0008, 2'b11},
    '{4'hc, 3'h0, 8'h00, 1'b1, 4'h0, 16'h0008, 2'b11},
    '{4'hf, 3'h2, 8'h05, 1'b1, 4'h0, 16'h0008, 2'b10}
  };

  always #2 clk = ~clk;

  ladder_points_model u_pts (
    .input_pins      (input_pins),
    .timer_contact   (timer_contact),
    .counter_contact (counter_contact)
  );

  ladder_bit_logic_executor u_dut (
    .clk(clk), .rstn(rstn), .instr_valid(instr_valid), .instr_opcode(instr_opcode),
    .instr_class(instr_class), .instr_index(instr_index), .fault_clear(fault_clear),
    .input_pins(input_pins), .timer_contact(timer_contact),
    .counter_contact(counter_contact), .acc(acc), .coil_y(coil_y), .relay_m(relay_m),
    .instr_done(instr_done), .operand_fault(operand_fault), .stack_error(stack_error),
    .result_level(result_level), .block_level(block_level)
  );

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask : chk

  // Instructions are held across the sampling edge and checked one edge on.
  // Valid stays high between calls, so it never toggles twice in one step.
  task automatic run(input logic [3:0] op, input logic [2:0] c, input logic [7:0] i);
    instr_valid = 1'b1;
    instr_opcode = op;
    instr_class = c;
    instr_index = i;
    @(negedge clk);
  endtask : run

  task automatic complete_run;
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (1000) @(posedge clk);
    n_errors++;
    complete_run();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    repeat (8) @(negedge clk);
    foreach (rows[k]) begin
      run(rows[k].op, rows[k].c, rows[k].i);
      chk("acc", {15'h0, rows[k].a}, {15'h0, acc});
      chk("level", {12'h0, rows[k].l}, {12'h0, result_level});
      chk("coil", rows[k].y, coil_y);
      chk("relay", {14'h0, rows[k].m}, {14'h0, relay_m[159], relay_m[5]});
      chk("done", 16'h1, {15'h0, instr_done});
    end
    instr_valid = 1'b0;
    chk("block", 16'h1, {12'h0, block_level});
    chk("fault", 16'h1, {15'h0, operand_fault});
    fault_clear = 1'b1;
    @(negedge clk);
    fault_clear = 1'b0;
    chk("fault", 16'h0, {15'h0, operand_fault});
    run(4'hd, 3'h3, 8'h00);
    chk("fault", 16'h1, {15'h0, operand_fault});
    chk("coil", 16'h0008, coil_y);
    repeat (9) run(4'h9, 3'h0, 8'h00);
    instr_valid = 1'b0;
    chk("level", 16'h8, {12'h0, result_level});
    chk("serr", 16'h1, {15'h0, stack_error});
    fault_clear = 1'b1;
    @(negedge clk);
    fault_clear = 1'b0;
    chk("serr", 16'h0, {15'h0, stack_error});
    repeat (9) run(4'hb, 3'h0, 8'h00);
    instr_valid = 1'b0;
    chk("level", 16'h0, {12'h0, result_level});
    chk("serr", 16'h1, {15'h0, stack_error});
    rstn = 1'b0;
    @(negedge clk);
    chk("rcoil", 16'h0, coil_y);
    chk("rrelay", 16'h0, {15'h0, |relay_m});
    chk("rerr", 16'h0, {15'h0, stack_error | operand_fault | acc});
    chk("rlevel", 16'h0, {8'h0, result_level, block_level});
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    run(4'h1, 3'h3, 8'h00);
    chk("acc", 16'h1, {15'h0, acc});
    run(4'h0, 3'h0, 8'h00);
    instr_valid = 1'b0;
    chk("acc", 16'h1, {15'h0, acc});
    chk("done", 16'h1, {15'h0, instr_done});
    complete_run();
  end
endmodule : tb
